// ### common/irt_pkg.sv
// Constants, register map and state types of the infra-red ON_OFF_KEYING transmitter
package irt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register port and map (byte addresses)
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_PRESCALE   = 8'h04;
   localparam logic [7:0] REG_RISE       = 8'h08;
   localparam logic [7:0] REG_PERIOD     = 8'h0C;
   localparam logic [7:0] REG_BITLEN     = 8'h10;
   localparam logic [7:0] REG_START_ADDR = 8'h14;
   localparam logic [7:0] REG_START      = 8'h18;
   localparam logic [7:0] REG_STATUS     = 8'h1C;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h24;
   localparam logic [7:0] REG_PROGRESS   = 8'h28;

   // Field positions
   localparam int CTRL_ENABLE_BIT  = 0;
   localparam int CTRL_INVERT_BIT  = 1;
   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_WAIT_BIT    = 1;
   localparam int IRQ_DONE_BIT     = 0;
   localparam int IRQ_REFUSED_BIT  = 1;
   localparam int IRQ_UNDERRUN_BIT = 2;
   localparam int IRQ_W            = 3;

   // Sizes of the bit array
   localparam int          WORD_BITS = 32;
   localparam int          MAX_WORDS = 128;
   localparam logic [12:0] MIN_BITS  = 13'h0001;
   localparam logic [12:0] MAX_BITS  = 13'h1000;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;

   // Values after reset
   localparam logic [3:0]  RST_PRESCALE = 4'h0;
   localparam logic [15:0] RST_RISE     = 16'h0000;
   localparam logic [15:0] RST_PERIOD   = 16'h0001;
   localparam logic [15:0] RST_BITLEN   = 16'h0001;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SEND} irt_state_type;

endpackage

// ### design/irt_transmitter.sv
// Infra-red on-off-keying transmitter with word fetch engine and registers
//
// Summary of operation
// [R1] Timer tick every 2^carrier_prescale_exponent peripheral clocks.
// [R2] Carrier low from cycle start until carrier_rise_count ticks, then high.
// [R3] Carrier cycle ends after carrier_period_count ticks, carrier back low.
// [R4] Each bit lasts bit_length_in_carriers whole carrier periods.
// [R5] Output is carrier AND current data bit.
// [R6] output_invert flips the polarity of the final output.
// [R7] done_irq_enable selects whether completion raises the interrupt.
// [R8] Bits come from up to 128 32-bit words at the start address.
// [R9] Start carries 1..4096 bits; exactly that many are sent.
// [R10] MSB first; last partial word uses only its top bits.
// [R11] Words are fetched autonomously over the memory port while sending.
// [R12] Busy status reads true while a transmission is in progress.
// [R13] After disabling, software reconfigures and re-enables before other use.
// [R14] Software routes the output pin before enabling, avoiding glitches.
// [R15] Software fills the array with already encoded bits.
// [R16] Output rests inactive when idle; busy clears as done is raised.
`timescale 1ns/1ns

module irt_transmitter
   import irt_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_write_i,
   input  wire logic              reg_read_i,
   output logic      [31:0]       reg_rdata_o,
   output logic                   mem_req_o,
   output logic      [31:0]       mem_addr_o,
   input  wire logic [31:0]       mem_rdata_i,
   input  wire logic              mem_ack_i,
   output logic                   ir_waveform_output_o,
   output logic                   irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State record

   typedef struct packed
   {
      logic                 enable;
      logic                 output_invert;
      logic [3:0]           carrier_prescale_exponent;
      logic [15:0]          carrier_rise_count;
      logic [15:0]          carrier_period_count;
      logic [15:0]          bit_length_in_carriers;
      logic [31:0]          start_addr;
      logic [IRQ_W-1:0]     irq_status;
      logic [IRQ_W-1:0]     irq_mask;
      irt_state_type        state;
      logic [15:0]          presc_cnt;
      logic [15:0]          tick_cnt;
      logic [15:0]          carrier_cnt;
      logic [12:0]          bits_left;
      logic [7:0]           words_left;
      logic [4:0]           bit_pos;
      logic [31:0]          shift_word;
      logic [31:0]          next_word;
      logic                 next_valid;
      logic                 fetch_pending;
      logic [31:0]          fetch_addr;
      logic                 pin;
      logic [31:0]          rdata;
   } irt_regs_type;

   irt_regs_type r;
   irt_regs_type next_r;

   ////////////////////////////////////////////////////////////////////////////
   // Derived combinational terms

   logic [15:0]      presc_limit;
   logic [15:0]      period_last;
   logic [15:0]      bitlen_last;
   logic             tick;
   logic             period_end;
   logic             bit_end;
   logic             carrier_on;
   logic             sending;
   logic             wr_start;
   logic             start_ok;
   logic [12:0]      start_count;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clear;
   logic [12:0]      words_needed;

   always_comb
   begin
      presc_limit = (16'h0001 << r.carrier_prescale_exponent) - 16'h0001; // R1
      // A zero period or bit length behaves as one, never as a stall
      period_last = (r.carrier_period_count == 16'h0000) ? 16'h0000
                    : r.carrier_period_count - 16'h0001;
      bitlen_last = (r.bit_length_in_carriers == 16'h0000) ? 16'h0000
                    : r.bit_length_in_carriers - 16'h0001;
      sending     = (r.state == ST_SEND);
      tick        = sending && (r.presc_cnt == presc_limit); // R1
      period_end  = tick && (r.tick_cnt >= period_last); // R3
      bit_end     = period_end && (r.carrier_cnt >= bitlen_last); // R4
      carrier_on  = (r.tick_cnt >= r.carrier_rise_count); // R2
      wr_start    = reg_write_i && (reg_addr_i == REG_START);
      start_count = reg_wdata_i[12:0];
      start_ok    = wr_start && r.enable && (r.state == ST_IDLE) &&
                    (start_count >= MIN_BITS) && (start_count <= MAX_BITS)
                    && (reg_wdata_i[31:13] == 19'h00000); // R9
      words_needed = (start_count + 13'h001F) >> 5; // R8
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb
   begin
      next_r    = r;
      irq_set   = '0;
      irq_clear = '0;
      next_r.rdata = 32'h0000_0000;

      // Register writes
      if (reg_write_i)
      begin
         unique case (reg_addr_i)
            REG_CTRL:
            begin
               next_r.enable        = reg_wdata_i[CTRL_ENABLE_BIT];
               next_r.output_invert = reg_wdata_i[CTRL_INVERT_BIT]; // R6
            end
            REG_PRESCALE:   next_r.carrier_prescale_exponent = reg_wdata_i[3:0];
            REG_RISE:       next_r.carrier_rise_count        = reg_wdata_i[15:0];
            REG_PERIOD:     next_r.carrier_period_count      = reg_wdata_i[15:0];
            REG_BITLEN:     next_r.bit_length_in_carriers    = reg_wdata_i[15:0];
            REG_START_ADDR: next_r.start_addr = {reg_wdata_i[31:2], 2'b00};
            REG_IRQ_STATUS: irq_clear = reg_wdata_i[IRQ_W-1:0];
            REG_IRQ_MASK:   next_r.irq_mask = reg_wdata_i[IRQ_W-1:0]; // R7
            default:        next_r.rdata = 32'h0000_0000;
         endcase
      end

      // Register reads: data stands in the following cycle only
      if (reg_read_i)
      begin
         unique case (reg_addr_i)
            REG_CTRL:
               next_r.rdata = {30'h0, r.output_invert, r.enable};
            REG_PRESCALE:   next_r.rdata = {28'h0, r.carrier_prescale_exponent};
            REG_RISE:       next_r.rdata = {16'h0, r.carrier_rise_count};
            REG_PERIOD:     next_r.rdata = {16'h0, r.carrier_period_count};
            REG_BITLEN:     next_r.rdata = {16'h0, r.bit_length_in_carriers};
            REG_START_ADDR: next_r.rdata = r.start_addr;
            REG_STATUS:
               next_r.rdata = {30'h0, (r.state == ST_FETCH),
                               (r.state != ST_IDLE)}; // R12
            REG_IRQ_STATUS: next_r.rdata = {29'h0, r.irq_status};
            REG_IRQ_MASK:   next_r.rdata = {29'h0, r.irq_mask};
            REG_PROGRESS:   next_r.rdata = {19'h0, r.bits_left};
            default:        next_r.rdata = 32'h0000_0000;
         endcase
      end

      // Start request
      if (wr_start && !start_ok)
      begin
         irq_set[IRQ_REFUSED_BIT] = 1'b1;
      end
      if (start_ok)
      begin
         next_r.state         = ST_FETCH; // R11
         next_r.bits_left     = start_count; // R9
         next_r.words_left    = words_needed[7:0]; // R8
         next_r.fetch_addr    = r.start_addr;
         next_r.next_valid    = 1'b0;
         next_r.fetch_pending = 1'b0;
      end

      // Waveform timing
      if (sending)
      begin
         next_r.presc_cnt = tick ? 16'h0000 : r.presc_cnt + 16'h0001; // R1
         if (tick)
         begin
            next_r.tick_cnt = period_end ? 16'h0000
                              : r.tick_cnt + 16'h0001; // R3
         end
         if (period_end)
         begin
            next_r.carrier_cnt = bit_end ? 16'h0000
                                 : r.carrier_cnt + 16'h0001; // R4
         end
         if (bit_end)
         begin
            if (r.bits_left == MIN_BITS)
            begin
               // Busy drops in the same cycle that done is flagged
               next_r.state = ST_IDLE; // R16
               irq_set[IRQ_DONE_BIT] = 1'b1; // R7
            end
            else
            begin
               next_r.bits_left = r.bits_left - 13'h0001; // R9
               if (r.bit_pos == 5'h1F)
               begin
                  if (r.next_valid)
                  begin
                     next_r.shift_word = r.next_word; // R10
                     next_r.next_valid = 1'b0;
                     next_r.bit_pos    = 5'h00;
                  end
                  else
                  begin
                     // Memory too slow: pause with output at rest
                     next_r.state = ST_FETCH;
                     irq_set[IRQ_UNDERRUN_BIT] = 1'b1;
                  end
               end
               else
               begin
                  next_r.shift_word = {r.shift_word[30:0], 1'b0}; // R10
                  next_r.bit_pos    = r.bit_pos + 5'h01;
               end
            end
         end
      end

      // Waiting for a word: load it and restart the carrier cycle
      if (r.state == ST_FETCH && r.next_valid)
      begin
         next_r.state       = ST_SEND;
         next_r.shift_word  = r.next_word;
         next_r.next_valid  = 1'b0;
         next_r.bit_pos     = 5'h00;
         next_r.presc_cnt   = 16'h0000;
         next_r.tick_cnt    = 16'h0000;
         next_r.carrier_cnt = 16'h0000;
      end

      // Fetch engine keeps one word ahead of the shifter
      if (r.fetch_pending && mem_ack_i)
      begin
         next_r.fetch_pending = 1'b0;
         next_r.next_word     = mem_rdata_i; // R11
         next_r.next_valid    = 1'b1;
         next_r.words_left    = r.words_left - 8'h01;
         next_r.fetch_addr    = r.fetch_addr + WORD_STEP;
      end
      else if (!r.fetch_pending && !r.next_valid && r.words_left != 8'h00
               && r.state != ST_IDLE)
      begin
         next_r.fetch_pending = 1'b1; // R11
      end

      // Disable aborts everything; the port is left free one cycle after enable clears
      if (!r.enable)
      begin
         next_r.state         = ST_IDLE;
         next_r.fetch_pending = 1'b0;
         next_r.next_valid    = 1'b0;
         next_r.words_left    = 8'h00;
      end

      // Sticky flags: a new event wins over a clear in the same cycle
      next_r.irq_status = (r.irq_status & ~irq_clear) | irq_set;

      // Output stage; polarity applied last
      next_r.pin = r.output_invert ^
                   (sending && carrier_on && r.shift_word[31]); // R5 R6 R16
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         r.enable                    <= 1'b0;
         r.output_invert             <= 1'b0;
         r.carrier_prescale_exponent <= RST_PRESCALE;
         r.carrier_rise_count        <= RST_RISE;
         r.carrier_period_count      <= RST_PERIOD;
         r.bit_length_in_carriers    <= RST_BITLEN;
         r.start_addr                <= 32'h0000_0000;
         r.irq_status                <= '0;
         r.irq_mask                  <= RST_IRQ_MASK;
         r.state                     <= ST_IDLE;
         r.presc_cnt                 <= 16'h0000;
         r.tick_cnt                  <= 16'h0000;
         r.carrier_cnt               <= 16'h0000;
         r.bits_left                 <= 13'h0000;
         r.words_left                <= 8'h00;
         r.bit_pos                   <= 5'h00;
         r.shift_word                <= 32'h0000_0000;
         r.next_word                 <= 32'h0000_0000;
         r.next_valid                <= 1'b0;
         r.fetch_pending             <= 1'b0;
         r.fetch_addr                <= 32'h0000_0000;
         r.pin                       <= 1'b0;
         r.rdata                     <= 32'h0000_0000;
      end
      else
      begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata_o          = r.rdata;
   assign mem_req_o            = r.fetch_pending;
   assign mem_addr_o           = r.fetch_addr;
   assign ir_waveform_output_o = r.pin;
   assign irq_o                = |(r.irq_status & r.irq_mask); // R7

endmodule

// ### tb/irt_mem_model.sv
// Memory model serving the transmitter's word fetches
`timescale 1ns/1ns
module irt_mem_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        mem_req_i,
   input  wire logic [31:0] mem_addr_i,
   input  wire logic [3:0]  wait_i,
   output logic      [31:0] mem_rdata_o,
   output logic             mem_ack_o,
   output logic      [7:0]  acks_o
);
   // Encoded bit array, filled by the bench
   logic [31:0] words [0:127];
   logic [3:0]  wait_cnt;

   // Data inverted after the answer cycle and on each idle cycle, so it shows again every other idle cycle; held while a request waits
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= 32'h0;
         wait_cnt    <= 4'h0;
         acks_o      <= 8'h0;
      end
      else if (mem_ack_o)
      begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
      end
      else if (mem_req_i && wait_cnt == wait_i)
      begin
         mem_ack_o   <= 1'b1;
         mem_rdata_o <= words[mem_addr_i[8:2]];
         wait_cnt    <= 4'h0;
         acks_o      <= acks_o + 8'h1;
      end
      else if (mem_req_i)
         wait_cnt <= wait_cnt + 4'h1;
      else
      begin
         // A withdrawn request must not leave a part-counted wait behind
         mem_rdata_o <= ~mem_rdata_o;
         wait_cnt    <= 4'h0;
      end
endmodule

// ### tb/irt_transmitter_sva.sv
// Port assertions of the infra-red transmitter and their bind
`timescale 1ns/1ns
module irt_transmitter_sva
(
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   input wire logic        reg_write_i,
   input wire logic        reg_read_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        mem_req_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic        mem_ack_i,
   input wire logic        ir_waveform_output_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////////////////////////
   // A write to REG_CTRL may disable the block and drop the fetch
   // A disable write drops the request one cycle late, so skip that cycle
   sequence s_wait;
      mem_req_o && !mem_ack_i && !reg_write_i && !$past(reg_write_i);
   endsequence
   sequence s_taken;
      mem_req_o && mem_ack_i;
   endsequence

   a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 0)
      else $error("read data outside slot");
   a_rdata_once: assert property (reg_read_i ##1 !reg_read_i |=> !reg_rdata_o)
      else $error("read data held too long");
   a_req_hold: assert property (s_wait |=> mem_req_o)
      else $error("fetch dropped unanswered");
   a_addr_stable: assert property (s_wait |=> $stable(mem_addr_o))
      else $error("fetch address moved");
   a_req_drop: assert property (s_taken |=> !mem_req_o)
      else $error("fetch kept after answer");
   a_addr_align: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
      else $error("fetch address not word aligned");
   a_irq_clear: assert property ($fell(irq_o) |-> $past(reg_write_i))
      else $error("irq fell without a write");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |=>
      !mem_req_o && !irq_o && !ir_waveform_output_o)
      else $error("outputs active in reset");
endmodule

bind irt_transmitter irt_transmitter_sva irt_transmitter_sva_inst (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_write_i(reg_write_i),
   .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
   .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
   .ir_waveform_output_o(ir_waveform_output_o), .irq_o(irq_o));

// ### tb/irt_transmitter_tb.sv
// Self-checking bench of the infra-red transmitter
`timescale 1ns/1ns
module irt_transmitter_tb;
   import irt_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b, wr_s, rd_s, req, ack, out, irq, act_lvl, counting;
   logic [7:0]  addr, acks;
   logic [3:0]  wsel;
   logic [31:0] wdata, rdata, maddr, mdata, got, act_cnt;
   int          fail_count;
   int          compares;

   always #25 clk = ~clk;

   irt_transmitter irt_transmitter_inst (
      .clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata),
      .mem_req_o(req), .mem_addr_o(maddr), .mem_rdata_i(mdata),
      .mem_ack_i(ack), .ir_waveform_output_o(out), .irq_o(irq));
   irt_mem_model irt_mem_model_inst (
      .clk_i(clk), .rst_b_i(rst_b), .mem_req_i(req), .mem_addr_i(maddr),
      .wait_i(wsel), .mem_rdata_o(mdata), .mem_ack_o(ack), .acks_o(acks));

   // Active output clocks, whatever the polarity
   always @(posedge clk)
      if (counting && out === act_lvl)
         act_cnt <= act_cnt + 32'h1;
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      got = rdata;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, string m);
      rd(a);
      check(got, e, m);
   endtask

   task automatic end_sim;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Start a transfer, poll busy, then judge output and fetches
   task automatic run(input logic [31:0] n, input logic lvl,
                      input logic [7:0] words, input logic [31:0] exp);
      logic [7:0] n0;
      act_lvl = lvl;
      act_cnt = 32'h0;
      n0 = acks;
      counting = 1'b1;
      wr(REG_START, n);
      rd(REG_STATUS);
      check({31'h0, got[0]}, 32'h1, "not busy");
      for (int i = 0; i < 500 && got[0] !== 1'b0; i++)
         rd(REG_STATUS);
      check({31'h0, got[0]}, 32'h0, "stuck busy");
      repeat (4) @(posedge clk);
      counting = 1'b0;
      check(act_cnt, exp, "active clocks");
      check({24'h0, acks - n0}, {24'h0, words}, "fetches");
      check({31'h0, out}, {31'h0, ~lvl}, "rest level");
   endtask

   task automatic t_refuse;
      wr(REG_IRQ_MASK, 32'h2);
      wr(REG_START, 32'h4);
      // Output path is fixed before this first enable
      wr(REG_CTRL, 32'h1);
      wr(REG_START, 32'h0);
      wr(REG_START, 32'h1001);
      rc(REG_STATUS, 32'h0, "refused start ran");
      rc(REG_IRQ_STATUS, 32'h2, "refusal flag");
      check({31'h0, irq}, 32'h1, "refusal irq");
      wr(REG_IRQ_STATUS, 32'h2);
      check({31'h0, irq}, 32'h0, "irq stuck");
   endtask

   // Pattern 1011, two carriers a bit, two high ticks of two clocks
   task automatic t_irq;
      irt_mem_model_inst.words[0] = 32'hB000_0000;
      wr(REG_PRESCALE, 32'h1);
      wr(REG_RISE, 32'h1);
      wr(REG_PERIOD, 32'h3);
      wr(REG_BITLEN, 32'h2);
      wr(REG_IRQ_MASK, 32'h1);
      run(32'h4, 1'b1, 8'h1, 32'h18);
      check({31'h0, irq}, 32'h1, "no done irq");
      rc(REG_IRQ_STATUS, 32'h1, "done flag");
      wr(REG_IRQ_STATUS, 32'h1);
      check({31'h0, irq}, 32'h0, "irq stuck");
   endtask

   // 35 bits inverted: only top 3 bits of the all-ones second word count
   task automatic t_poll;
      irt_mem_model_inst.words[16] = 32'hFFFF_FFFF;
      irt_mem_model_inst.words[17] = 32'hFFFF_FFFF;
      wsel = 4'h3;
      // Polarity first: the rest level lags one clock and must not count
      wr(REG_CTRL, 32'h3);
      wr(REG_BITLEN, 32'h1);
      wr(REG_START_ADDR, 32'h40);
      wr(REG_IRQ_MASK, 32'h0);
      run(32'h23, 1'b0, 8'h2, 32'h8C);
      check({31'h0, irq}, 32'h0, "masked irq");
      rc(REG_IRQ_STATUS, 32'h1, "done flag");
   endtask

   // Busy refusal, progress, abort by disable, then re-arm and resend
   task automatic t_abort;
      wr(REG_CTRL, 32'h1);
      wr(REG_IRQ_STATUS, 32'h7);
      wr(REG_START_ADDR, 32'h40);
      wr(REG_START, 32'h40);
      wr(REG_START, 32'h1);
      rc(REG_PROGRESS, 32'h40, "bits left at start");
      rc(REG_STATUS, 32'h3, "waiting for first word");
      repeat (20) @(posedge clk);
      wr(REG_CTRL, 32'h0);
      rc(REG_STATUS, 32'h0, "abort left busy");
      rc(REG_IRQ_STATUS, 32'h2, "busy refusal or abort flags");
      check({31'h0, out}, 32'h0, "abort rest level");
      // Reconfigure and re-enable before the next start
      wr(REG_START_ADDR, 32'h0);
      wr(REG_BITLEN, 32'h2);
      wr(REG_CTRL, 32'h1);
      run(32'h4, 1'b1, 8'h1, 32'h18);
   endtask

   initial
   begin
      {rst_b, wr_s, rd_s, counting, act_lvl, addr, wdata, wsel} = '0;
      act_cnt = 32'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rc(REG_PERIOD, 32'h1, "period reset");
      rc(REG_BITLEN, 32'h1, "bit length reset");
      rc(REG_RISE, 32'h0, "rise reset");
      rc(REG_STATUS, 32'h0, "idle status");
      wr(8'h3C, 32'hFFFF_FFFF);
      rc(8'h3C, 32'h0, "unmapped read");
      t_refuse;
      t_irq;
      t_poll;
      t_abort;
      end_sim;
   end

   initial
   begin
      #2000000;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim;
   end
endmodule
